// ### rtl/group_share_config_regs.sv
// group sharing configuration registers with output-good sequencing
// Contract
// - hold five-bit rail group identity, bits 12:8
// - phase position from bits 14:13, values 0-3
// - phase count from bits 3:0: odd field plus one, even field gives one
// - wait programmed delay before asserting output-good
// - output-good delay from 0 to 5000 ms
// - round written delay to nearest millisecond
// - store eight-bit ramp gain for sharing rails
// - sharing selects share ramp, disables high bandwidth
// - after output-good, restore high-bandwidth loop
// - sharing rails never do soft turn-off
// - accept coil value 0-100 microhenry
// - mask bit one blocks snapshot, zero allows
// - mask bits 13-8: group..aux overvoltage faults
// - mask bits 7-4: current and input faults
// - mask bits 3-0: temperature and output voltage
`timescale 1ns/1ps
module group_share_config_regs #(
  parameter int CYCLES_PER_MS = gsc_pkg::CYCLES_PER_MS_DEF
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic wr_valid,
  input wire logic [7:0] wr_cmd,
  input wire logic [1:0] wr_len,
  input wire logic wr_pec_ok,
  input wire logic [15:0] wr_data,
  input wire logic rd_req,
  input wire logic [7:0] rd_cmd,
  output logic [15:0] rd_data,
  output logic [1:0] rd_len,
  output logic rd_ack,
  output logic cmd_reject,
  input wire logic vout_above_thr,
  input wire logic rail_on,
  input wire logic [gsc_pkg::FLT_COUNT-1:0] fault_event,
  output logic output_ok_pin,
  output logic [4:0] rail_group_id,
  output logic [1:0] phase_position,
  output logic [3:0] phase_count,
  output logic sharing_mode,
  output logic share_ramp_sel,
  output logic high_bw_loop_en,
  output logic soft_off_allow,
  output logic [7:0] ramp_gain,
  output logic [15:0] coil_uh,
  output logic snapshot_req,
  output logic [gsc_pkg::FLT_COUNT-1:0] snapshot_src
);
  import gsc_pkg::*;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  logic [15:0] gbc_q;
  logic [15:0] delay_raw_q;
  logic [15:0] delay_ms_q;
  logic [7:0] gain_q;
  logic [15:0] coil_raw_q;
  logic [15:0] coil_uh_q;
  logic [15:0] mask_q;
  logic [15:0] rd_data_q;
  logic [1:0] rd_len_q;
  logic rd_ack_q;
  logic cmd_reject_q;
  logic thr_m_q;
  logic thr_s_q;
  logic ok_q;
  logic [3:0] phase_count_q;
  logic sharing_q;
  logic share_ramp_q;
  logic high_bw_q;
  logic soft_off_q;
  logic snap_req_q;
  logic [FLT_COUNT-1:0] snap_src_q;
  rail_state_t st_q;
  rail_state_t st_d;

  ok_timer_if okt ();

  // write decode
  wire w_gbc = (wr_cmd == CMD_GROUP_BUS_CONFIG);
  wire w_delay = (wr_cmd == CMD_OUTPUT_OK_DELAY);
  wire w_gain = (wr_cmd == CMD_SHARED_RAMP_GAIN);
  wire w_coil = (wr_cmd == CMD_COIL_VALUE);
  wire w_mask = (wr_cmd == CMD_FAULT_CAPTURE_MASK);
  wire w_hit = w_gbc | w_delay | w_gain | w_coil | w_mask;
  wire w_len_ok = w_gain ? (wr_len == LEN_BYTE) : (wr_len == LEN_WORD);
  wire [15:0] wr_rounded = lin_round(wr_data);
  wire delay_ok = (wr_rounded <= OK_DELAY_MAX_MS);
  wire coil_ok = (wr_rounded <= COIL_MAX_UH);
  wire pos_ok = !wr_data[PHASE_POS_RSV];
  wire data_ok = (w_gbc & pos_ok) | (w_delay & delay_ok) | w_gain | (w_coil & coil_ok) | w_mask;
  wire accept = wr_valid & wr_pec_ok & w_hit & w_len_ok & data_ok;

  // read decode
  wire r_gbc = (rd_cmd == CMD_GROUP_BUS_CONFIG);
  wire r_delay = (rd_cmd == CMD_OUTPUT_OK_DELAY);
  wire r_gain = (rd_cmd == CMD_SHARED_RAMP_GAIN);
  wire r_coil = (rd_cmd == CMD_COIL_VALUE);
  wire r_mask = (rd_cmd == CMD_FAULT_CAPTURE_MASK);
  wire r_hit = r_gbc | r_delay | r_gain | r_coil | r_mask;
  wire [15:0] rd_word = r_gbc ? gbc_q :
                        r_delay ? delay_raw_q :
                        r_gain ? {8'h00, gain_q} :
                        r_coil ? coil_raw_q :
                        r_mask ? mask_q : 16'h0000;

  // phases field must be odd to name a sharing rail
  wire [3:0] phases_f = gbc_q[PHASES_MSB:PHASES_LSB];
  wire sharing = phases_f[0];
  wire [3:0] phases_dec = sharing ? (phases_f + 4'h1) : 4'h1;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      gbc_q <= GBC_RST;
      delay_raw_q <= DELAY_RST;
      delay_ms_q <= DELAY_RST;
      gain_q <= GAIN_RST;
      coil_raw_q <= COIL_RST;
      coil_uh_q <= COIL_RST;
      mask_q <= MASK_RST;
    end else if (accept) begin
      if (w_gbc) begin
        gbc_q <= wr_data & GBC_WR_MASK;
      end
      if (w_delay) begin
        delay_raw_q <= wr_data;
        delay_ms_q <= wr_rounded;
      end
      if (w_gain) begin
        gain_q <= wr_data[7:0];
      end
      if (w_coil) begin
        coil_raw_q <= wr_data;
        coil_uh_q <= wr_rounded;
      end
      if (w_mask) begin
        mask_q <= wr_data & MASK_WR_MASK;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rd_data_q <= 16'h0000;
      rd_len_q <= 2'h0;
      rd_ack_q <= 1'b0;
      cmd_reject_q <= 1'b0;
    end else begin
      rd_data_q <= rd_req ? rd_word : rd_data_q;
      rd_len_q <= rd_req ? (r_gain ? LEN_BYTE : LEN_WORD) : rd_len_q;
      rd_ack_q <= rd_req & r_hit;
      cmd_reject_q <= wr_valid & w_hit & !accept;
    end
  end

  // comparator output is analog-side, so it is synchronised
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      thr_m_q <= 1'b0;
      thr_s_q <= 1'b0;
    end else begin
      thr_m_q <= vout_above_thr;
      thr_s_q <= thr_m_q;
    end
  end

  // rail sequencing: ramp until output-good, then normal run
  assign okt.arm = thr_s_q & rail_on;
  assign okt.delay_ms = delay_ms_q;

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_OFF: begin
        if (rail_on) begin
          st_d = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (!rail_on) begin
          st_d = ST_OFF;
        end else if (okt.done) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!rail_on) begin
          st_d = ST_OFF;
        end else if (!thr_s_q) begin
          st_d = ST_RAMP;
        end
      end
      default: begin
        st_d = ST_OFF;
      end
    endcase
  end

  ok_delay_timer #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_timer (
    .clock(clock),
    .rst_b(rst_b),
    .t(okt.tmr)
  );

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_q <= ST_OFF;
      ok_q <= 1'b0;
      phase_count_q <= 4'h1;
      sharing_q <= 1'b0;
      share_ramp_q <= 1'b0;
      high_bw_q <= 1'b1;
      soft_off_q <= 1'b1;
    end else begin
      st_q <= st_d;
      ok_q <= (st_d == ST_RUN);
      phase_count_q <= phases_dec;
      sharing_q <= sharing;
      share_ramp_q <= sharing & (st_d != ST_RUN);
      high_bw_q <= !sharing | (st_d == ST_RUN);
      soft_off_q <= !sharing;
    end
  end

  // snapshot trigger gating, one lane per fault
  wire [FLT_COUNT-1:0] snap_hit;
  genvar gi;
  generate
    for (gi = 0; gi < FLT_COUNT; gi++) begin : g_snap
      assign snap_hit[gi] = fault_event[gi] & !mask_q[gi];
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      snap_req_q <= 1'b0;
      snap_src_q <= '0;
    end else begin
      snap_req_q <= |snap_hit;
      snap_src_q <= snap_hit;
    end
  end

  assign rd_data = rd_data_q;
  assign rd_len = rd_len_q;
  assign rd_ack = rd_ack_q;
  assign cmd_reject = cmd_reject_q;
  assign output_ok_pin = ok_q;
  assign rail_group_id = gbc_q[RAIL_ID_MSB:RAIL_ID_LSB];
  assign phase_position = gbc_q[PHASE_POS_MSB:PHASE_POS_LSB];
  assign phase_count = phase_count_q;
  assign sharing_mode = sharing_q;
  assign share_ramp_sel = share_ramp_q;
  assign high_bw_loop_en = high_bw_q;
  assign soft_off_allow = soft_off_q;
  assign ramp_gain = gain_q;
  assign coil_uh = coil_uh_q;
  assign snapshot_req = snap_req_q;
  assign snapshot_src = snap_src_q;

  chk_rail_id_store: assert property (
    accept && w_gbc |=> rail_group_id == $past(wr_data[RAIL_ID_MSB:RAIL_ID_LSB]))
    else $error("rail group id not stored");
  chk_phase_four: assert property (
    $past(gbc_q[PHASES_MSB:PHASES_LSB]) == 4'h3 |-> phase_count == 4'h4)
    else $error("phase count decode wrong");
  chk_ok_after_thr: assert property (
    $rose(output_ok_pin) |-> $past(thr_s_q, 2) && $past(rail_on, 2))
    else $error("output good without threshold");
  chk_delay_limit: assert property (
    delay_ms_q <= OK_DELAY_MAX_MS) else $error("delay above limit");
  chk_delay_round: assert property (
    accept && w_delay && wr_data == 16'hF803 |=> delay_ms_q == 16'h0002)
    else $error("delay not rounded");
  chk_share_ramp_bw: assert property (
    sharing_q && !output_ok_pin && $past(st_q) == ST_RAMP && st_q == ST_RAMP
    |-> share_ramp_sel && !high_bw_loop_en) else $error("share ramp not selected");
  chk_bw_after_ok: assert property (
    output_ok_pin |-> high_bw_loop_en && !share_ramp_sel)
    else $error("high bandwidth not restored");
  chk_no_soft_off: assert property (
    sharing_mode |-> !soft_off_allow) else $error("soft off with sharing");
  chk_snap_masked: assert property (
    snapshot_req |-> $past(|(fault_event & ~mask_q[FLT_COUNT-1:0])))
    else $error("snapshot from masked fault");
  chk_reserved_zero: assert property (
    gbc_q[GBC_RSV_MSB:GBC_RSV_LSB] == 4'h0 && mask_q[15:FLT_COUNT] == 2'h0)
    else $error("reserved bits set");
  chk_len_guard: assert property (
    wr_valid && w_gain && wr_len != LEN_BYTE |=> $stable(gain_q) && cmd_reject)
    else $error("wrong length write took effect");

  cov_delay_write: cover property (accept && w_delay);
  cov_share_ok: cover property (sharing_q && $rose(output_ok_pin));
  cov_snapshot: cover property (snapshot_req);
  cov_reject: cover property (cmd_reject);
endmodule

// ### rtl/gsc_pkg.sv
// constants, types and helpers for the group sharing configuration registers
package gsc_pkg;
  localparam logic [7:0] CMD_GROUP_BUS_CONFIG = 8'hD3;
  localparam logic [7:0] CMD_OUTPUT_OK_DELAY = 8'hD4;
  localparam logic [7:0] CMD_SHARED_RAMP_GAIN = 8'hD5;
  localparam logic [7:0] CMD_COIL_VALUE = 8'hD6;
  localparam logic [7:0] CMD_FAULT_CAPTURE_MASK = 8'hD7;

  localparam logic [1:0] LEN_BYTE = 2'h1;
  localparam logic [1:0] LEN_WORD = 2'h2;

  // group-bus configuration word layout
  localparam int RAIL_ID_MSB = 12;
  localparam int RAIL_ID_LSB = 8;
  localparam int PHASE_POS_MSB = 14;
  localparam int PHASE_POS_LSB = 13;
  localparam int PHASE_POS_RSV = 15;
  localparam int PHASES_MSB = 3;
  localparam int PHASES_LSB = 0;
  localparam int GBC_RSV_MSB = 7;
  localparam int GBC_RSV_LSB = 4;
  localparam logic [15:0] GBC_WR_MASK = 16'hFF0F;

  // fault capture mask bit positions
  localparam int FLT_GROUP_RAIL = 13;
  localparam int FLT_PHASE = 12;
  localparam int FLT_PROCESSOR = 11;
  localparam int FLT_CHECKSUM = 10;
  localparam int FLT_AUX_UV = 9;
  localparam int FLT_AUX_OV = 8;
  localparam int FLT_IOUT_UC = 7;
  localparam int FLT_IOUT_OC = 6;
  localparam int FLT_VIN_UV = 5;
  localparam int FLT_VIN_OV = 4;
  localparam int FLT_UNDER_TEMP = 3;
  localparam int FLT_OVER_TEMP = 2;
  localparam int FLT_VOUT_UV = 1;
  localparam int FLT_VOUT_OV = 0;
  localparam int FLT_COUNT = 14;
  localparam logic [15:0] MASK_WR_MASK = 16'h3FFF;

  // reset values
  localparam logic [15:0] GBC_RST = 16'h0000;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [7:0] GAIN_RST = 8'h00;
  localparam logic [15:0] COIL_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;

  // limits in whole units
  localparam logic [15:0] OK_DELAY_MAX_MS = 16'h1388;
  localparam logic [15:0] COIL_MAX_UH = 16'h0064;

  // linear data format: 5-bit signed exponent over 11-bit signed mantissa
  localparam int LIN_EXP_MSB = 15;
  localparam int LIN_EXP_LSB = 11;
  localparam int LIN_MANT_MSB = 10;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int CYCLES_PER_MS_DEF = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_RAMP = 3'b010,
    ST_RUN = 3'b100
  } rail_state_t;

  // linear value to nearest whole unit, negatives to zero, saturating
  function automatic logic [15:0] lin_round(input logic [15:0] w);
    logic [4:0] sh;
    logic [31:0] mag;
    sh = 5'h00;
    mag = 32'h0;
    if (w[LIN_MANT_MSB]) begin
      mag = 32'h0;
    end else if (!w[LIN_EXP_MSB]) begin
      sh = w[LIN_EXP_MSB:LIN_EXP_LSB];
      mag = {21'h0, w[LIN_MANT_MSB:0]} << sh;
    end else begin
      sh = 5'(~w[LIN_EXP_MSB:LIN_EXP_LSB] + 5'h01);
      mag = ({21'h0, w[LIN_MANT_MSB:0]} + (32'h1 << (sh - 5'h01))) >> sh;
    end
    return (mag > 32'h0000FFFF) ? 16'hFFFF : mag[15:0];
  endfunction
endpackage

// ### rtl/ok_delay_timer.sv
// millisecond delay timer for the output-good indication
`timescale 1ns/1ps
module ok_delay_timer #(
  parameter int CYCLES_PER_MS = gsc_pkg::CYCLES_PER_MS_DEF
) (
  input wire logic clock,
  input wire logic rst_b,
  ok_timer_if.tmr t
);
  import gsc_pkg::*;

  logic [31:0] pre_q;
  logic [15:0] ms_q;
  logic done_q;
  wire ms_tick = (pre_q == 32'(CYCLES_PER_MS - 1));
  wire reached = (ms_q >= t.delay_ms);

  // dropping arm restarts the whole delay
  always_ff @(posedge clock) begin
    if (!rst_b || !t.arm) begin
      pre_q <= 32'h0;
      ms_q <= 16'h0000;
      done_q <= 1'b0;
    end else if (reached) begin
      done_q <= 1'b1;
    end else if (ms_tick) begin
      pre_q <= 32'h0;
      ms_q <= ms_q + 16'h0001;
    end else begin
      pre_q <= pre_q + 32'h1;
    end
  end

  assign t.done = done_q;

  chk_done_needs_arm: assert property (@(posedge clock) disable iff (!rst_b)
    t.done |-> $past(t.arm)) else $error("delay done without arm");
endmodule

// ### rtl/ok_timer_if.sv
// carrier between the rail sequencer and the output-good delay timer
`timescale 1ns/1ps
interface ok_timer_if;
  logic [15:0] delay_ms;
  logic arm;
  logic done;
  modport ctrl (output delay_ms, output arm, input done);
  modport tmr (input delay_ms, input arm, output done);
endinterface

// ### testbench/pmbus_host_model.sv
// framing-layer host model issuing whole register transactions
`timescale 1ns/1ps
module pmbus_host_model (
  input wire logic clock,
  output logic wr_valid,
  output logic [7:0] wr_cmd,
  output logic [1:0] wr_len,
  output logic wr_pec_ok,
  output logic [15:0] wr_data,
  output logic rd_req,
  output logic [7:0] rd_cmd
);
  initial begin
    wr_valid = 1'b0;
    wr_cmd = 8'h00;
    wr_len = 2'h0;
    wr_pec_ok = 1'b0;
    wr_data = 16'h0000;
    rd_req = 1'b0;
    rd_cmd = 8'h00;
  end

  // callers keep one group identity and gains of 1..5 only
  task automatic write_txn(input logic [7:0] c, input logic [1:0] l, input logic p,
                           input logic [15:0] d);
    @(negedge clock);
    wr_valid = 1'b1;
    wr_cmd = c;
    wr_len = l;
    wr_pec_ok = p;
    wr_data = d;
    @(negedge clock);
    wr_valid = 1'b0;
    // released lines show the inverse so a stale sample cannot match
    wr_cmd = ~c;
    wr_len = ~l;
    wr_pec_ok = ~p;
    wr_data = ~d;
  endtask

  task automatic read_txn(input logic [7:0] c);
    @(negedge clock);
    rd_req = 1'b1;
    rd_cmd = c;
    @(negedge clock);
    rd_req = 1'b0;
    rd_cmd = ~c;
  endtask
endmodule

// ### testbench/tb_group_share_config_regs.sv
// self-checking bench for the group sharing configuration registers
`timescale 1ns/1ps
module tb_group_share_config_regs;
  import gsc_pkg::*;
  localparam int CPM = 4;
  typedef struct packed {
    logic [7:0] cmd;
    logic [1:0] len;
    logic pec;
    logic [15:0] data;
    logic rej;
    logic ack;
    logic [15:0] rdv;
    logic [1:0] rlen;
  } row_t;
  localparam row_t ROWS [13] = '{
    '{8'hD3, LEN_WORD, 1'b1, 16'h6A15, 1'b0, 1'b1, 16'h6A05, LEN_WORD},
    '{8'hD3, LEN_WORD, 1'b1, 16'h8001, 1'b1, 1'b1, 16'h6A05, LEN_WORD},
    '{8'hD4, LEN_WORD, 1'b1, 16'h1A72, 1'b1, 1'b1, 16'h0000, LEN_WORD},
    '{8'hD4, LEN_WORD, 1'b1, 16'h1A71, 1'b0, 1'b1, 16'h1A71, LEN_WORD},
    '{8'hD4, LEN_WORD, 1'b1, 16'hF803, 1'b0, 1'b1, 16'hF803, LEN_WORD},
    '{8'hD4, LEN_BYTE, 1'b1, 16'h0011, 1'b1, 1'b1, 16'hF803, LEN_WORD},
    '{8'hD4, LEN_WORD, 1'b0, 16'h0011, 1'b1, 1'b1, 16'hF803, LEN_WORD},
    '{8'hD5, LEN_BYTE, 1'b1, 16'h0003, 1'b0, 1'b1, 16'h0003, LEN_BYTE},
    '{8'hD5, LEN_WORD, 1'b1, 16'h0004, 1'b1, 1'b1, 16'h0003, LEN_BYTE},
    '{8'hD6, LEN_WORD, 1'b1, 16'h0065, 1'b1, 1'b1, 16'h0000, LEN_WORD},
    '{8'hD6, LEN_WORD, 1'b1, 16'h0064, 1'b0, 1'b1, 16'h0064, LEN_WORD},
    '{8'hD7, LEN_WORD, 1'b1, 16'hFFFF, 1'b0, 1'b1, 16'h3FFF, LEN_WORD},
    '{8'hD8, LEN_WORD, 1'b1, 16'h1234, 1'b0, 1'b0, 16'h0000, LEN_WORD}};

  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic wr_valid, wr_pec_ok, rd_req, rd_ack, cmd_reject, output_ok_pin;
  logic [7:0] wr_cmd, rd_cmd, ramp_gain;
  logic [1:0] wr_len, rd_len, phase_position;
  logic [15:0] wr_data, rd_data, coil_uh, rv;
  logic vout_above_thr = 1'b0;
  logic rail_on = 1'b0;
  logic [FLT_COUNT-1:0] fault_event = '0;
  logic [FLT_COUNT-1:0] snapshot_src;
  logic [4:0] rail_group_id;
  logic [3:0] phase_count;
  logic sharing_mode, share_ramp_sel, high_bw_loop_en, soft_off_allow, snapshot_req, seen;
  int mismatches = 0;
  int total_checks = 0;
  int n;

  always #50 clock = ~clock;

  pmbus_host_model host (.clock(clock), .wr_valid(wr_valid), .wr_cmd(wr_cmd),
    .wr_len(wr_len), .wr_pec_ok(wr_pec_ok), .wr_data(wr_data), .rd_req(rd_req),
    .rd_cmd(rd_cmd));

  group_share_config_regs #(.CYCLES_PER_MS(CPM)) dut (.clock(clock), .rst_b(rst_b),
    .wr_valid(wr_valid), .wr_cmd(wr_cmd), .wr_len(wr_len), .wr_pec_ok(wr_pec_ok),
    .wr_data(wr_data), .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_data(rd_data),
    .rd_len(rd_len), .rd_ack(rd_ack), .cmd_reject(cmd_reject),
    .vout_above_thr(vout_above_thr), .rail_on(rail_on), .fault_event(fault_event),
    .output_ok_pin(output_ok_pin), .rail_group_id(rail_group_id),
    .phase_position(phase_position), .phase_count(phase_count),
    .sharing_mode(sharing_mode), .share_ramp_sel(share_ramp_sel),
    .high_bw_loop_en(high_bw_loop_en), .soft_off_allow(soft_off_allow),
    .ramp_gain(ramp_gain), .coil_uh(coil_uh), .snapshot_req(snapshot_req),
    .snapshot_src(snapshot_src));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // pulses are caught by sampling every falling edge for a few cycles
  task automatic wr(input logic [7:0] c, input logic [1:0] l, input logic p,
                    input logic [15:0] d);
    seen = 1'b0;
    host.write_txn(c, l, p, d);
    for (int i = 0; i < 3; i++) begin
      seen |= (cmd_reject === 1'b1);
      @(negedge clock);
    end
  endtask

  task automatic rd(input logic [7:0] c);
    seen = 1'b0;
    host.read_txn(c);
    for (int i = 0; i < 3; i++) begin
      seen |= (rd_ack === 1'b1);
      @(negedge clock);
    end
  endtask

  task automatic snap(input logic [FLT_COUNT-1:0] f);
    seen = 1'b0;
    rv = 16'h0000;
    fault_event = f;
    @(negedge clock);
    fault_event = '0;
    for (int i = 0; i < 3; i++) begin
      if (snapshot_req === 1'b1) begin
        seen = 1'b1;
        rv = {2'b00, snapshot_src};
      end
      @(negedge clock);
    end
  endtask

  initial begin
    repeat (6) @(negedge clock);
    rst_b = 1'b1;
    for (int c = 8'hD3; c <= 8'hD7; c++) begin
      rd(8'(c));
      chk("reset read", 16'h0000, rd_data);
    end
    chk("reset phases", 16'h0001, {12'h000, phase_count});
    chk("reset loop", 16'h0003, {14'h0000, high_bw_loop_en, soft_off_allow});
    $display("test reset done");
    foreach (ROWS[i]) begin
      wr(ROWS[i].cmd, ROWS[i].len, ROWS[i].pec, ROWS[i].data);
      chk("reject", {15'h0000, ROWS[i].rej}, {15'h0000, seen});
      rd(ROWS[i].cmd);
      chk("ack", {15'h0000, ROWS[i].ack}, {15'h0000, seen});
      chk("read data", ROWS[i].rdv, rd_data);
      if (ROWS[i].ack) begin
        chk("read length", {14'h0000, ROWS[i].rlen}, {14'h0000, rd_len});
      end
    end
    chk("ramp gain", 16'h0003, {8'h00, ramp_gain});
    chk("coil", 16'h0064, coil_uh);
    $display("test table done");
    for (int j = 0; j < 4; j++) begin
      wr(CMD_GROUP_BUS_CONFIG, LEN_WORD, 1'b1, {1'b0, 2'(j), 5'h0A, 4'h0, 4'(2 * j + 1)});
      chk("group id", 16'h000A, {11'h000, rail_group_id});
      chk("position", 16'(j), {14'h0000, phase_position});
      chk("phases", 16'(2 * j + 2), {12'h000, phase_count});
      chk("sharing", 16'h0002, {14'h0000, sharing_mode, high_bw_loop_en});
      chk("ramp select", 16'h0001, {15'h0000, share_ramp_sel});
    end
    $display("test config done");
    n = 0;
    rail_on = 1'b1;
    vout_above_thr = 1'b1;
    while (output_ok_pin !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    if (n >= 40) begin
      mismatches++;
      $display("unexpected output good: expected high, seen low");
      report_and_stop();
    end
    // two sync stages, 2 ms of CPM cycles plus one, one output register
    chk("good delay", 16'(2 * CPM + 4), 16'(n));
    chk("run loop", 16'h0001, {15'h0000, high_bw_loop_en});
    chk("run ramp", 16'h0000, {15'h0000, share_ramp_sel});
    chk("soft off", 16'h0000, {15'h0000, soft_off_allow});
    vout_above_thr = 1'b0;
    repeat (4) @(negedge clock);
    chk("good drop", 16'h0000, {14'h0000, output_ok_pin, high_bw_loop_en});
    rail_on = 1'b0;
    // even phases field means a standalone rail
    wr(CMD_GROUP_BUS_CONFIG, LEN_WORD, 1'b1, 16'h0A02);
    chk("standalone", 16'h000B, {9'h000, phase_count, sharing_mode, high_bw_loop_en,
      soft_off_allow});
    $display("test output good done");
    snap('1);
    chk("masked snapshot", 16'h0000, {15'h0000, seen});
    for (int b = 0; b < FLT_COUNT; b++) begin
      wr(CMD_FAULT_CAPTURE_MASK, LEN_WORD, 1'b1, 16'h3FFF & ~(16'h0001 << b));
      snap('1);
      chk("snapshot source", 16'h0001 << b, rv);
    end
    $display("test snapshot done");
    rst_b = 1'b0;
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    rd(CMD_GROUP_BUS_CONFIG);
    chk("second reset", 16'h0000, rd_data);
    chk("second reset phases", 16'h0001, {12'h000, phase_count});
    $display("test second reset done");
    report_and_stop();
  end
endmodule
